// ==== logic/rim_pkg.sv ====
// rim_pkg: shared constants and types for the remote i/o image manager.
// assumes one system clock; the configuration port and mode inputs are
// driven by logic on that clock.
package rim_pkg;

   // operating modes of the controller
   typedef enum logic [1:0] {MODE_CONFIG, MODE_IDLE, MODE_RUN} rim_mode_t;

   // i/o tag types; byte size follows the type, bool and byte both one byte
   typedef enum logic [1:0] {TAG_BOOL, TAG_BYTE, TAG_WORD, TAG_DWORD} rim_tag_t;

   // tag list depth and payload limits
   localparam int MAX_TAGS = 8;
   localparam int TAG_BYTES_MAX = 4;
   localparam int PAY_MAX = 32;
   localparam int LEN_W = 6;

   // register offsets (byte addresses)
   localparam logic [7:0] REG_SEL = 8'h00;
   localparam logic [7:0] REG_CNT = 8'h04;
   localparam logic [7:0] REG_TAGS = 8'h08;
   localparam logic [7:0] REG_STAT = 8'h0C;

   // field positions inside the registers
   localparam int SEL_HOLD_BIT = 8;
   localparam int CNT_LIN_LSB = 0;
   localparam int CNT_TEST_LSB = 4;
   localparam int CNT_MON_LSB = 8;
   localparam int CNT_NTAG_LSB = 12;
   localparam int STAT_MODE_LSB = 8;
   localparam int STAT_HOLD_BIT = 12;
   localparam int STAT_STDL_BIT = 13;

   // reset values: nothing selected, clear policy
   localparam logic [5:0] SEL_RESET = 6'h00;
   localparam logic HOLD_RESET = 1'b0;
   localparam logic [2:0] CNT3_RESET = 3'h0;
   localparam logic [1:0] CNT2_RESET = 2'h0;
   localparam logic [3:0] NTAG_RESET = 4'h0;
   localparam logic [15:0] TAGS_RESET = 16'h0000;

   // selection of payload items
   typedef struct packed {
      logic mon_out;
      logic mon_in;
      logic test;
      logic lout;
      logic lin;
      logic gen;
   } rim_sel_t;

   // complete layout configuration
   typedef struct packed {
      rim_sel_t sel;
      logic [2:0] lin_n;
      logic [1:0] test_n;
      logic [2:0] mon_n;
      logic [3:0] ntag;
      logic [15:0] tag_types;
   } rim_cfg_t;

   // fatal events that clear even held data
   typedef struct packed {
      logic critical;
      logic abort;
   } rim_fault_t;

endpackage : rim_pkg

// ==== logic/rim_image_mgr.sv ====
// rim_image_mgr: keeps the safety and standard remote i/o images and
// packs the slave input payload from status, monitor and tag bytes.
// assumes mode, faults and received data arrive on i_ref_clk; the stored
// hold setting comes from non-volatile storage and is synchronised here.

// Summary of operation
// - mode change or power-on clears safety area
// - comm error clears only that connection
// - clear policy: error clears slave output area
// - clear policy: idle entry clears slave input
// - hold policy: error keeps slave output data
// - hold policy: idle entry keeps slave input
// - critical, abort or power-on always clear
// - clear default, policy change needs power cycle
// - status, then monitor, then tag sections
// - any single data class alone is accepted
// - status items in fixed order from zero
// - unselected items take no space, no gaps
// - older units: no monitor, input status word
// - tag size follows its type
// - input status up to N, test up to M
// - status and monitor byte counts are configurable
// - non-safety items carry no safety marking
// - standard link data is always non-safety
// - input monitor then output monitor follow status
// - tags follow in registration order, packed
module rim_image_mgr #(
   parameter int N_CONN = 2,
   parameter int SAFE_BYTES = 4,
   parameter int STD_BYTES = 8,
   parameter int LIN_MAX = 2,
   parameter int TST_MAX = 1,
   parameter bit LEGACY = 1'b0
) (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   // configuration port
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   // operating mode and faults
   input wire rim_pkg::rim_mode_t i_mode,
   input wire rim_pkg::rim_fault_t i_fault,
   // stored hold setting (pin) and value to be stored
   input wire logic i_hold_nv,
   output logic o_hold_cfg,
   // safety connections
   input wire logic [N_CONN-1:0] i_safe_valid,
   input wire logic [N_CONN-1:0] i_safe_err,
   input wire logic [N_CONN-1:0][SAFE_BYTES-1:0][7:0] i_safe_data,
   output logic [N_CONN-1:0][SAFE_BYTES-1:0][7:0] o_safe_area,
   // standard slave output connection
   input wire logic i_std_valid,
   input wire logic i_std_err,
   input wire logic [STD_BYTES-1:0][7:0] i_std_data,
   output logic [STD_BYTES-1:0][7:0] o_std_rx_area,
   // payload sources
   input wire logic [7:0] i_gen_status,
   input wire logic [LIN_MAX-1:0][7:0] i_lin_status,
   input wire logic [7:0] i_lout_status,
   input wire logic [TST_MAX-1:0][7:0] i_test_status,
   input wire logic [LIN_MAX-1:0][7:0] i_mon_in,
   input wire logic [7:0] i_mon_out,
   input wire logic [rim_pkg::MAX_TAGS-1:0][31:0] i_tag_data,
   input wire logic i_link_std,
   // packed slave input payload
   output logic [rim_pkg::PAY_MAX-1:0][7:0] o_tx_payload,
   output logic [rim_pkg::PAY_MAX-1:0] o_tx_safe_mask,
   output logic [rim_pkg::LEN_W-1:0] o_tx_len
);

   localparam int NCAND = 3 + 2 * LIN_MAX + TST_MAX
                          + rim_pkg::MAX_TAGS * rim_pkg::TAG_BYTES_MAX;

   // byte size of one tag
   function automatic logic [2:0] tag_size(input logic [1:0] t);
      unique case (rim_pkg::rim_tag_t'(t))
         rim_pkg::TAG_BOOL: tag_size = 3'h1;
         rim_pkg::TAG_BYTE: tag_size = 3'h1;
         rim_pkg::TAG_WORD: tag_size = 3'h2;
         rim_pkg::TAG_DWORD: tag_size = 3'h4;
      endcase
   endfunction : tag_size

   // limit a written byte count to what the variant offers
   function automatic logic [2:0] clamp3(input logic [2:0] v, input int lim);
      if (int'(v) > lim)
         clamp3 = 3'(lim);
      else
         clamp3 = v;
   endfunction : clamp3

   rim_pkg::rim_cfg_t cfg;
   rim_pkg::rim_cfg_t act;
   rim_pkg::rim_mode_t mode_q;
   logic hold_req;
   logic hold_s1;
   logic hold_s2;
   logic hold_act;
   logic hold_done;
   logic mode_chg;
   logic to_cfg;
   logic to_idle;
   logic enter_op;
   logic fatal;
   logic [rim_pkg::PAY_MAX-1:0][7:0] next_pay;
   logic [rim_pkg::PAY_MAX-1:0] next_mask;
   logic [rim_pkg::LEN_W-1:0] next_len;
   logic [NCAND-1:0][7:0] cand_byte;
   logic [NCAND-1:0] cand_en;
   logic [NCAND-1:0] cand_safe;

   // mode transitions seen against the previous cycle
   assign mode_chg = (i_mode != mode_q);
   assign to_cfg = mode_chg && (i_mode == rim_pkg::MODE_CONFIG);
   assign to_idle = mode_chg && (i_mode == rim_pkg::MODE_IDLE)
                    && (mode_q == rim_pkg::MODE_RUN);
   assign enter_op = mode_chg && (mode_q == rim_pkg::MODE_CONFIG);
   assign fatal = i_fault.critical || i_fault.abort;

   // previous mode; power-on starts from configuration
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rstn)
         mode_q <= rim_pkg::MODE_CONFIG;
      else
         mode_q <= i_mode;
   end

   // pin synchroniser, no reset: it must be settled at release
   always_ff @(posedge i_ref_clk)
   begin
      hold_s1 <= i_hold_nv;
      hold_s2 <= hold_s1;
   end

   // policy is caught once after power-on and frozen until the next
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rstn)
      begin
         hold_act <= rim_pkg::HOLD_RESET;
         hold_done <= 1'b0;
      end
      else if (!hold_done)
      begin
         hold_act <= hold_s2;
         hold_done <= 1'b1;
      end
   end

   // configuration registers; byte counts are clamped to the variant, the tag count is not
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rstn)
      begin
         cfg.sel <= rim_pkg::SEL_RESET;
         cfg.lin_n <= rim_pkg::CNT3_RESET;
         cfg.test_n <= rim_pkg::CNT2_RESET;
         cfg.mon_n <= rim_pkg::CNT3_RESET;
         cfg.ntag <= rim_pkg::NTAG_RESET;
         cfg.tag_types <= rim_pkg::TAGS_RESET;
         hold_req <= rim_pkg::HOLD_RESET;
      end
      else if (i_wr)
      begin
         unique case (i_addr)
            rim_pkg::REG_SEL:
            begin
               cfg.sel <= rim_pkg::rim_sel_t'(i_wdata[5:0]);
               hold_req <= i_wdata[rim_pkg::SEL_HOLD_BIT];
            end
            rim_pkg::REG_CNT:
            begin
               // byte-unit counts, limited per variant
               cfg.lin_n <= clamp3(i_wdata[rim_pkg::CNT_LIN_LSB +: 3], LIN_MAX);
               cfg.test_n <= 2'(clamp3({1'b0, i_wdata[rim_pkg::CNT_TEST_LSB +: 2]},
                                       TST_MAX));
               cfg.mon_n <= clamp3(i_wdata[rim_pkg::CNT_MON_LSB +: 3], LIN_MAX);
               cfg.ntag <= i_wdata[rim_pkg::CNT_NTAG_LSB +: 4];
            end
            rim_pkg::REG_TAGS: cfg.tag_types <= i_wdata[15:0];
            default: ;
         endcase
      end
   end

   // register readback, data one cycle after the strobe
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rstn)
         o_rdata <= 32'h00000000;
      else if (i_rd)
      begin
         unique case (i_addr)
            rim_pkg::REG_SEL:
               o_rdata <= {23'h000000, hold_req, 2'h0, cfg.sel};
            rim_pkg::REG_CNT:
               o_rdata <= {16'h0000, cfg.ntag, 1'b0, cfg.mon_n, 2'h0, cfg.test_n,
                           1'b0, cfg.lin_n};
            rim_pkg::REG_TAGS:
               o_rdata <= {16'h0000, cfg.tag_types};
            rim_pkg::REG_STAT:
               o_rdata <= {18'h00000, i_link_std, hold_act, 2'h0, 2'(mode_q),
                           2'h0, o_tx_len};
            default: o_rdata <= 32'h00000000;
         endcase
      end
      else
         o_rdata <= 32'h00000000;
   end

   // value for the non-volatile store; takes effect only after power cycle
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rstn)
         o_hold_cfg <= rim_pkg::HOLD_RESET;
      else
         o_hold_cfg <= hold_req;
   end

   // the layout snapshot changes only when configuration is left, so the
   // payload never reshuffles under a running master
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rstn)
         act <= '0;
      else if (enter_op)
      begin
         act <= cfg;
         if (LEGACY)
         begin
            act.sel.mon_in <= 1'b0;
            act.sel.mon_out <= 1'b0;
            act.lin_n <= 3'h2; // local input status as one word
         end
      end
   end

   // candidate bytes in wire order: status, monitor, tags
   always_comb
   begin
      int k;
      int nb;
      k = 0;
      nb = 0;
      cand_byte = '0;
      cand_en = '0;
      cand_safe = '0;
      // status in fixed order from offset zero
      cand_byte[k] = i_gen_status;
      cand_en[k] = act.sel.gen;
      k = k + 1;
      for (int b = 0; b < LIN_MAX; b++)
      begin
         cand_byte[k] = i_lin_status[b];
         cand_en[k] = act.sel.lin && (b < int'(act.lin_n));
         cand_safe[k] = 1'b1;
         k = k + 1;
      end
      cand_byte[k] = i_lout_status;
      cand_en[k] = act.sel.lout;
      cand_safe[k] = 1'b1;
      k = k + 1;
      for (int b = 0; b < TST_MAX; b++)
      begin
         cand_byte[k] = i_test_status[b];
         cand_en[k] = act.sel.test && (b < int'(act.test_n));
         k = k + 1;
      end
      // monitor bytes after status, absent on older units
      for (int b = 0; b < LIN_MAX; b++)
      begin
         cand_byte[k] = i_mon_in[b];
         cand_en[k] = !LEGACY && act.sel.mon_in && (b < int'(act.mon_n));
         cand_safe[k] = 1'b1;
         k = k + 1;
      end
      cand_byte[k] = i_mon_out;
      cand_en[k] = !LEGACY && act.sel.mon_out;
      k = k + 1;
      // tags in registration order, sized by type
      for (int t = 0; t < rim_pkg::MAX_TAGS; t++)
      begin
         nb = int'(tag_size(act.tag_types[2*t +: 2]));
         for (int b = 0; b < rim_pkg::TAG_BYTES_MAX; b++)
         begin
            cand_byte[k] = i_tag_data[t][8*b +: 8];
            cand_en[k] = (t < int'(act.ntag)) && (b < nb);
            cand_safe[k] = 1'b1;
            k = k + 1;
         end
      end
   end

   // compaction: enabled bytes move forward, leaving no holes
   always_comb
   begin
      int pos;
      pos = 0;
      next_pay = '0;
      next_mask = '0;
      for (int c = 0; c < NCAND; c++)
      begin
         if (cand_en[c] && (pos < rim_pkg::PAY_MAX))
         begin
            next_pay[pos] = cand_byte[c];
            // non-safety items and standard links stay unmarked
            next_mask[pos] = cand_safe[c] && !i_link_std;
            pos = pos + 1;
         end
      end
      next_len = pos[rim_pkg::LEN_W-1:0];
   end

   // slave input image toward the standard master
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rstn)
      begin
         o_tx_payload <= '0;
         o_tx_safe_mask <= '0;
         o_tx_len <= '0;
      end
      else if (fatal || to_cfg)
      begin
         o_tx_payload <= '0;
         o_tx_safe_mask <= '0;
      end
      else if (to_idle && !hold_act)
      begin
         o_tx_payload <= '0;
         o_tx_safe_mask <= '0;
      end
      else if (i_mode == rim_pkg::MODE_RUN)
      begin
         o_tx_payload <= next_pay;
         o_tx_safe_mask <= next_mask;
         o_tx_len <= next_len;
      end
      // idle under hold keeps the last image
   end

   // standard slave output area feeding the user program
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rstn)
         o_std_rx_area <= '0;
      else if (fatal || to_cfg)
         o_std_rx_area <= '0;
      else if ((i_std_err || to_idle) && !hold_act)
         o_std_rx_area <= '0;
      else if (i_std_err)
         o_std_rx_area <= o_std_rx_area; // last data kept
      else if (i_std_valid && (i_mode != rim_pkg::MODE_CONFIG))
         o_std_rx_area <= i_std_data;
   end

   // safety areas: a clear always beats new data
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rstn)
         o_safe_area <= '0;
      else
      begin
         for (int c = 0; c < N_CONN; c++)
         begin
            if (mode_chg)
               o_safe_area[c] <= '0;
            else if (i_safe_err[c])
               o_safe_area[c] <= '0; // only the failed connection
            else if (i_safe_valid[c])
               o_safe_area[c] <= i_safe_data[c];
         end
      end
   end

   property p_safe_mode;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      mode_chg |=> (o_safe_area == '0);
   endproperty
   a_safe_mode: assert property (p_safe_mode)
      else $error("safety area not cleared on mode change");

   property p_safe_conn;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (i_safe_err[0] && !mode_chg && !i_safe_err[N_CONN-1] && i_safe_valid[N_CONN-1])
      |=> (o_safe_area[0] == '0) && (o_safe_area[N_CONN-1] == $past(i_safe_data[N_CONN-1]));
   endproperty
   a_safe_conn: assert property (p_safe_conn)
      else $error("connection error clear not confined to its connection");

   property p_std_cfg;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      to_cfg |=> (o_std_rx_area == '0) && (o_tx_payload == '0);
   endproperty
   a_std_cfg: assert property (p_std_cfg)
      else $error("standard area not cleared on entry to configuration");

   property p_clr_err;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (i_std_err && !hold_act) |=> (o_std_rx_area == '0);
   endproperty
   a_clr_err: assert property (p_clr_err)
      else $error("clear policy did not clear slave output area");

   property p_clr_idle;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (to_idle && !hold_act) |=> (o_tx_payload == '0) && (o_tx_safe_mask == '0);
   endproperty
   a_clr_idle: assert property (p_clr_idle)
      else $error("clear policy did not clear slave input image");

   property p_hold_err;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (i_std_err && hold_act && !fatal && !to_cfg) |=> $stable(o_std_rx_area);
   endproperty
   a_hold_err: assert property (p_hold_err)
      else $error("hold policy lost slave output data");

   property p_hold_idle;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (to_idle && hold_act && !fatal) |=> $stable(o_tx_payload);
   endproperty
   a_hold_idle: assert property (p_hold_idle)
      else $error("hold policy lost slave input image");

   property p_fatal;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      fatal |=> (o_tx_payload == '0) && (o_std_rx_area == '0);
   endproperty
   a_fatal: assert property (p_fatal)
      else $error("critical error or abort did not clear held data");

   property p_hold_fixed;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (hold_done && $past(hold_done)) |-> $stable(hold_act);
   endproperty
   a_hold_fixed: assert property (p_hold_fixed)
      else $error("hold policy changed without a power cycle");

   property p_gen_first;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (act.sel.gen && (i_mode == rim_pkg::MODE_RUN) && !mode_chg && !fatal)
      |=> (o_tx_payload[0] == $past(i_gen_status));
   endproperty
   a_gen_first: assert property (p_gen_first)
      else $error("general status not at offset zero");

   property p_layout_frozen;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      !enter_op |=> $stable(act);
   endproperty
   a_layout_frozen: assert property (p_layout_frozen)
      else $error("layout changed outside entry from configuration");

endmodule : rim_image_mgr

// ==== verification/rim_master_model.sv ====
// rim_master_model: far-side master feeding safety and standard data.
// assumes requests come from the bench on i_ref_clk, after reset.
module rim_master_model #(
   parameter int NC = 2,
   parameter int SB = 4,
   parameter int DB = 8
) (
   // clock and answer lag
   input wire logic i_ref_clk,
   input wire logic [1:0] i_lag,
   // bench requests; bit NC is the standard connection
   input wire logic [NC:0] i_send,
   input wire logic [NC:0] i_fail,
   // toward the block
   output logic [NC:0] o_valid,
   output logic [NC:0] o_err,
   output logic [NC-1:0][SB-1:0][7:0] o_safe_data,
   output logic [DB-1:0][7:0] o_std_data
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0][NC:0] send_q;
   logic [3:0][NC:0] fail_q;

   // request pipes, so the master can answer late
   always_ff @(posedge i_ref_clk)
   begin
      send_q <= {send_q[2:0], i_send};
      fail_q <= {fail_q[2:0], i_fail};
   end
   assign o_valid = send_q[i_lag];
   assign o_err = fail_q[i_lag];

   // inverted while not valid, so a stale value never matches
   always_comb
   begin
      for (int c = 0; c < NC; c++)
         for (int b = 0; b < SB; b++)
            o_safe_data[c][b] = {4'hA + c[3:0], b[3:0]} ^ {8{~o_valid[c]}};
      // standard data feeds no safety use here
      for (int b = 0; b < DB; b++)
         o_std_data[b] = {4'h5, b[3:0]} ^ {8{~o_valid[NC]}};
   end
endmodule : rim_master_model

// ==== verification/rim_image_mgr_bench.sv ====
// rim_image_mgr_bench: register tasks plus image and payload scenarios.
// assumes the package constants and a far-side master model.
module rim_image_mgr_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic i_ref_clk, i_rstn, i_wr, i_rd, i_hold_nv, o_hold_cfg, link;
   logic [7:0] i_addr, gen, lout, mout;
   logic [31:0] i_wdata, o_rdata, mask, rv;
   rim_pkg::rim_mode_t i_mode;
   rim_pkg::rim_fault_t i_fault;
   logic [2:0] valid, err, send, fail;
   logic [1:0] lag;
   logic [1:0][3:0][7:0] sdata, sarea;
   logic [7:0][7:0] ddata, darea;
   logic [1:0][7:0] lin, mon;
   logic [0:0][7:0] tst;
   logic [7:0][31:0] tags;
   logic [31:0][7:0] pay_q;
   logic [5:0] len;
   int errors, checks_done;

   rim_image_mgr i_rim_image_mgr (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .i_mode(i_mode), .i_fault(i_fault),
      .i_hold_nv(i_hold_nv), .o_hold_cfg(o_hold_cfg),
      .i_safe_valid(valid[1:0]), .i_safe_err(err[1:0]), .i_safe_data(sdata),
      .o_safe_area(sarea), .i_std_valid(valid[2]), .i_std_err(err[2]),
      .i_std_data(ddata), .o_std_rx_area(darea), .i_gen_status(gen),
      .i_lin_status(lin), .i_lout_status(lout), .i_test_status(tst),
      .i_mon_in(mon), .i_mon_out(mout), .i_tag_data(tags), .i_link_std(link),
      .o_tx_payload(pay_q), .o_tx_safe_mask(mask), .o_tx_len(len));

   rim_master_model i_rim_master_model (.i_ref_clk(i_ref_clk), .i_lag(lag),
      .i_send(send), .i_fail(fail), .o_valid(valid), .o_err(err),
      .o_safe_data(sdata), .o_std_data(ddata));

   task automatic conclude();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge i_ref_clk);
   endtask : cyc

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_ref_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
   endtask : wr

   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge i_ref_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      #1 rv = o_rdata;
   endtask : rd

   task automatic setm(input rim_pkg::rim_mode_t m);
      @(posedge i_ref_clk);
      i_mode <= m;
      cyc(4);
   endtask : setm

   task automatic kick(input logic [2:0] s, input logic [2:0] f);
      @(posedge i_ref_clk);
      send <= s;
      fail <= f;
      @(posedge i_ref_clk);
      send <= 3'h0;
      fail <= 3'h0;
      cyc(5);
   endtask : kick

   task automatic layout(input logic [31:0] s, input logic [31:0] c, input logic [31:0] t);
      wr(rim_pkg::REG_SEL, s);
      wr(rim_pkg::REG_CNT, c);
      wr(rim_pkg::REG_TAGS, t);
   endtask : layout

   // expected bytes packed low byte first; mask checked over len only
   task automatic pay(input logic [71:0] e, input int n, input logic [31:0] m);
      chk({26'h0, len}, n);
      for (int i = 0; i < n; i++)
         chk({24'h0, pay_q[i]}, {24'h0, e[8*i +: 8]});
      chk(mask & ((32'h1 << n) - 32'h1), m);
   endtask : pay

   task automatic rst();
      @(posedge i_ref_clk);
      i_rstn <= 1'b0;
      cyc(6);
      i_rstn <= 1'b1;
      cyc(2);
   endtask : rst

   initial
   begin
      i_ref_clk = 1'b0;
      forever #2.5 i_ref_clk = ~i_ref_clk;
   end

   // hang guard
   initial
   begin
      #100000;
      errors++;
      conclude();
   end

   initial
   begin
      {i_rstn, i_wr, i_rd, i_hold_nv, link, i_addr, i_wdata} = '0;
      {send, fail, lag, i_fault} = '0;
      i_mode = rim_pkg::MODE_CONFIG;
      gen = 8'h11;
      lin = {8'h22, 8'h21};
      lout = 8'h33;
      tst = 8'h44;
      mon = {8'h56, 8'h55};
      mout = 8'h66;
      for (int i = 0; i < 8; i++)
         tags[i] = {4'h8 + i[3:0], 4'h3, 4'h8 + i[3:0], 4'h2, 4'h8 + i[3:0], 4'h1,
            4'h8 + i[3:0], 4'h0};
      rst();
      chk({26'h0, len}, 32'h0);
      rd(rim_pkg::REG_STAT);
      chk({31'h0, rv[12]}, 32'h0);
      rd(8'h20);
      chk(rv, 32'h0);
      // hold request is only stored, not applied before power cycle
      layout(32'h10F, 32'h2017, 32'h9);
      chk({31'h0, o_hold_cfg}, 32'h1);
      rd(rim_pkg::REG_STAT);
      chk({31'h0, rv[12]}, 32'h0);
      setm(rim_pkg::MODE_RUN);
      pay(72'h9190804433222111, 8, 32'hEE);
      wr(rim_pkg::REG_SEL, 32'h0);
      cyc(3);
      pay(72'h9190804433222111, 8, 32'hEE);
      // safety images per connection, then the standard area and idle entry
      kick(3'h3, 3'h0);
      chk(sarea[1], 32'hB3B2B1B0);
      kick(3'h2, 3'h1);
      chk(sarea[0], 32'h0);
      chk(sarea[1], 32'hB3B2B1B0);
      kick(3'h4, 3'h0);
      chk(darea[3:0], 32'h53525150);
      kick(3'h0, 3'h4);
      chk(darea[7:4], 32'h0);
      kick(3'h4, 3'h0);
      setm(rim_pkg::MODE_IDLE);
      chk(sarea[1], 32'h0);
      chk(pay_q[3:0], 32'h0);
      chk(darea[3:0], 32'h0);
      setm(rim_pkg::MODE_CONFIG);
      link <= 1'b1;
      layout(32'h32, 32'h2102, 32'hC);
      setm(rim_pkg::MODE_RUN);
      pay(72'h939291908066552221, 9, 32'h0);
      setm(rim_pkg::MODE_CONFIG);
      link <= 1'b0;
      layout(32'h0, 32'h1000, 32'h3);
      setm(rim_pkg::MODE_RUN);
      pay(72'h83828180, 4, 32'hF);
      // power cycle with hold stored, slow master
      setm(rim_pkg::MODE_CONFIG);
      i_hold_nv <= 1'b1;
      lag <= 2'h2;
      rst();
      rd(rim_pkg::REG_STAT);
      chk({31'h0, rv[12]}, 32'h1);
      layout(32'h0, 32'h1000, 32'h3);
      for (int f = 0; f < 2; f++)
      begin
         setm(rim_pkg::MODE_RUN);
         kick(3'h4, 3'h0);
         kick(3'h0, 3'h4);
         chk(darea[7:4], 32'h57565554);
         setm(rim_pkg::MODE_IDLE);
         chk(pay_q[3:0], 32'h83828180);
         @(posedge i_ref_clk);
         i_fault.critical <= (f == 0);
         i_fault.abort <= (f == 1);
         @(posedge i_ref_clk);
         i_fault <= '0;
         cyc(2);
         chk(pay_q[3:0], 32'h0);
         chk(darea[3:0], 32'h0);
      end
      kick(3'h4, 3'h0);
      setm(rim_pkg::MODE_CONFIG);
      chk(darea[3:0], 32'h0);
      conclude();
   end
endmodule : rim_image_mgr_bench
